// ===== bcsch_pkg.sv
// shared constants and types of the bridge command, sleep and crc handler
package bcsch_pkg;

  // ************************************************************
  // device command codes
  // ************************************************************
  localparam logic [7:0] CMD_WRITE_CFG = 8'hd2;
  localparam logic [7:0] CMD_READ_CFG  = 8'he1;
  localparam logic [7:0] CMD_SLEEP     = 8'h1e;
  localparam logic [7:0] CMD_READ_REV  = 8'hc3;
  localparam logic [7:0] CMD_PACKET    = 8'h2d;

  // ************************************************************
  // configuration byte
  // ************************************************************
  localparam logic [1:0] RATE_100K    = 2'h0;
  localparam logic [1:0] RATE_400K    = 2'h1;
  localparam logic [1:0] RATE_900K    = 2'h2;
  localparam logic [1:0] RATE_UNUSED  = 2'h3;
  localparam logic [7:0] CFG_RESET    = 8'h01;
  localparam int         CFG_RATE_LSB = 0;
  localparam int         CFG_RATE_MSB = 1;
  localparam logic [5:0] CFG_UPPER    = 6'h00;

  // ************************************************************
  // status answers after a failed packet check, and the zero length value
  // ************************************************************
  localparam logic [7:0] STAT_CRC_ERR  = 8'h01;
  localparam logic [7:0] WSTAT_NO_I2C  = 8'hff;
  localparam logic [7:0] LEN_ZERO      = 8'h00;

  // ************************************************************
  // crc engines, both shifted least significant bit first
  // ************************************************************
  localparam logic [15:0] CRC16_POLY_REFL = 16'ha001;
  localparam logic [15:0] CRC16_INIT      = 16'h0000;
  localparam logic [7:0]  CRC8_POLY_REFL  = 8'h8c;
  localparam logic [7:0]  CRC8_INIT       = 8'h00;
  localparam logic [2:0]  ROM_BODY_BYTES  = 3'h7;

  // ************************************************************
  // command interpreter states
  // ************************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_CFG_WR, ST_ANSWER, ST_ADDR, ST_WLEN, ST_WDATA,
    ST_RLEN, ST_CRC_LO, ST_CRC_HI, ST_CHECK, ST_REPORT, ST_HOLD, ST_SLEEP
  } bcsch_state_type;

endpackage

// ===== bcsch_crc_if.sv
// byte-wide crc engine connection between a user and the engine
`timescale 1ns/100ps
interface bcsch_crc_if #(parameter int W = 16);
  logic         clear;
  logic         load;
  logic [7:0]   data;
  logic [W-1:0] value;

  modport engine (input clear, input load, input data, output value);
  modport user   (output clear, output load, output data, input value);
endinterface // bcsch_crc_if

// ===== bcsch_crc_engine.sv
// byte-per-clock reflected crc engine, width and polynomial as parameters
`timescale 1ns/100ps
module bcsch_crc_engine #(
  parameter int           W    = 16,
  parameter logic [W-1:0] POLY = '0,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic     clk,
  input wire logic     rst,
  bcsch_crc_if.engine  crc
);

  // eight serial steps folded into one clock, lsb of the byte first
  function automatic logic [W-1:0] step_byte(input logic [W-1:0] c, input logic [7:0] d);
    logic [W-1:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[0] ^ d[i])
        r = (r >> 1) ^ POLY;
      else
        r = r >> 1;
    end
    return r;
  endfunction

  // clear wins over load so a new frame never inherits old bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      crc.value <= INIT;
    else if (crc.clear)
      crc.value <= INIT;
    else if (crc.load)
      crc.value <= step_byte(crc.value, crc.data);
  end

endmodule // bcsch_crc_engine

// ===== bcsch_rom_id.sv
// builds the 64-bit rom identifier with its crc byte after reset
`timescale 1ns/100ps
module bcsch_rom_id
  import bcsch_pkg::*;
#(
  parameter logic [55:0] BODY = 56'h00_0000_0000_5a01  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst,
  output logic [63:0]      rom_id,
  output logic             ready
);

  logic [2:0] idx;

  bcsch_crc_if #(.W(8)) rom_crc ();

  bcsch_crc_engine #(
    .W    (8),
    .POLY (CRC8_POLY_REFL),
    .INIT (CRC8_INIT)
  ) u_crc8 (
    .clk (clk),
    .rst (rst),
    .crc (rom_crc.engine)
  );

  // feed the seven body bytes, low byte first
  assign rom_crc.clear = 1'b0;
  assign rom_crc.load  = !ready && (idx < ROM_BODY_BYTES);
  assign rom_crc.data  = BODY[{idx, 3'b000} +: 8];

  // crc lands in the top byte, sent as is without inversion
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      idx    <= 3'h0;
      ready  <= 1'b0;
      rom_id <= 64'h0;
    end
    else if (!ready)
    begin
      if (idx < ROM_BODY_BYTES)
        idx <= idx + 3'h1;
      else
      begin
        rom_id <= {rom_crc.value, BODY};
        ready  <= 1'b1;
      end
    end
  end

  a_rom_crc_top : assert property (@(posedge clk) disable iff (rst)
    $rose(ready) |-> (rom_id[63:56] == rom_crc.value) && (rom_id[55:0] == BODY))
    else $error("rom crc byte not placed on top");

  a_rom_true_form : assert property (@(posedge clk) disable iff (rst)
    ready |-> rom_id[63:56] == $past(rom_crc.value))
    else $error("rom crc byte not in true form");

endmodule // bcsch_rom_id

// ===== bcsch_top.sv
// command interpreter: configuration, sleep, revision and packet crc check
`timescale 1ns/100ps

// Function
// - rate select bits 1:0 choose 100k, 400k or 900k; reset value 400k.
// - read configuration returns the configuration byte on the next read byte.
// - device commands are taken only after a rom selection while idle, which is entered at reset, on bus reset or on wake.
// - sleep command enters low-current state and ignores all bus traffic.
// - sleep ends only on a rising edge of the wake input.
// - the sleep request pin enters the same sleep state.
// - read revision returns major nibble high, minor nibble low.
// - rom identifier top byte holds crc8 over the low 56 bits.
// - the rom crc byte is sent in true form.
// - packet crc16 uses x16+x15+x2+1, received inverted and compared inverted.
// - i2c operation starts only on crc match; mismatch sets the error flag.
// - error output is high whenever the crc error flag is set.
// - a valid bus reset clears the error output.
// - on crc failure status bit 0 is set and write status reads ff.
// - crc16 spans command, address with lsb zero, lengths, data and read count.
module bcsch_top
  import bcsch_pkg::*;
#(
  parameter logic [3:0]  REV_MAJOR = 4'h1,
  parameter logic [3:0]  REV_MINOR = 4'h0,
  parameter logic [55:0] ROM_BODY  = 56'h00_0000_0000_5a01  // arbitrary value
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        BUS_RESET,
  input  wire logic        ROM_SELECTED,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_BYTE,
  input  wire logic        TX_REQ,
  input  wire logic        SLEEP_N,
  input  wire logic        WAKE,
  output logic             TX_VALID,
  output logic [7:0]       TX_BYTE,
  output logic [1:0]       RATE_SELECT,
  output logic             I2C_GO,
  output logic [6:0]       I2C_ADDR,
  output logic [7:0]       I2C_WLEN,
  output logic [7:0]       I2C_RLEN,
  output logic             ERR_DETECTED,
  output logic             ASLEEP,
  output logic [63:0]      ROM_ID,
  output logic             ROM_ID_READY
);

  // ************************************************************
  // state and storage
  // ************************************************************
  bcsch_state_type state;
  bcsch_state_type next_state;
  logic            wake_prev;
  logic            wake_rise;
  logic [7:0]      data_left;
  logic [7:0]      rx_crc_lo;
  logic [15:0]     rx_crc;
  logic            err_set;
  logic            report_idx;
  logic            rx_take;

  bcsch_crc_if #(.W(16)) pkt_crc ();

  bcsch_crc_engine #(
    .W    (16),
    .POLY (CRC16_POLY_REFL),
    .INIT (CRC16_INIT)
  ) u_crc16 (
    .clk (CLK_SYS),
    .rst (RST),
    .crc (pkt_crc.engine)
  );

  bcsch_rom_id #(
    .BODY (ROM_BODY)
  ) u_rom_id (
    .clk    (CLK_SYS),
    .rst    (RST),
    .rom_id (ROM_ID),
    .ready  (ROM_ID_READY)
  );

  // ************************************************************
  // packet crc feed
  // ************************************************************
  assign wake_rise = WAKE && !wake_prev;
  assign rx_take   = RX_VALID && (state != ST_SLEEP);
  assign rx_crc    = {RX_BYTE, rx_crc_lo};

  // restart on every selection; the address byte is hashed with lsb zero
  assign pkt_crc.clear = ROM_SELECTED;
  assign pkt_crc.load  = rx_take && ((state == ST_CMD && RX_BYTE == CMD_PACKET)
                         || state == ST_ADDR || state == ST_WLEN
                         || state == ST_WDATA || state == ST_RLEN);
  assign pkt_crc.data  = (state == ST_ADDR) ? {RX_BYTE[7:1], 1'b0} : RX_BYTE;

  logic [15:0] rx_crc_full;
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      rx_crc_full <= 16'h0;
    else if (rx_take && state == ST_CRC_HI)
      rx_crc_full <= rx_crc;
  end

  // host sends the crc inverted, so the stored value is inverted back
  logic pkt_ok;
  assign pkt_ok = (~rx_crc_full == pkt_crc.value);

  // ************************************************************
  // next state
  // ************************************************************
  // sleep outranks bus reset so nothing on the bus can end it
  always_comb
  begin
    next_state = state;
    if (state == ST_SLEEP)
    begin
      if (wake_rise)
        next_state = ST_IDLE;
    end
    else if (!SLEEP_N)
      next_state = ST_SLEEP;
    else if (BUS_RESET)
      next_state = ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE:
          if (ROM_SELECTED)
            next_state = ST_CMD;
        ST_CMD:
          if (rx_take)
          begin
            case (RX_BYTE)
              CMD_WRITE_CFG: next_state = ST_CFG_WR;
              CMD_READ_CFG:  next_state = ST_ANSWER;
              CMD_READ_REV:  next_state = ST_ANSWER;
              CMD_SLEEP:     next_state = ST_SLEEP;
              CMD_PACKET:    next_state = ST_ADDR;
              default:       next_state = ST_HOLD;
            endcase
          end
        ST_CFG_WR:
          if (rx_take)
            next_state = ST_HOLD;
        ST_ANSWER:
          if (TX_REQ)
            next_state = ST_HOLD;
        ST_ADDR:
          if (rx_take)
            next_state = ST_WLEN;
        ST_WLEN:
          if (rx_take)
            next_state = (RX_BYTE == LEN_ZERO) ? ST_HOLD : ST_WDATA;
        ST_WDATA:
          if (rx_take && data_left == 8'h01)
            next_state = ST_RLEN;
        ST_RLEN:
          if (rx_take)
            next_state = (RX_BYTE == LEN_ZERO) ? ST_HOLD : ST_CRC_LO;
        ST_CRC_LO:
          if (rx_take)
            next_state = ST_CRC_HI;
        ST_CRC_HI:
          if (rx_take)
            next_state = ST_CHECK;
        ST_CHECK:
          next_state = pkt_ok ? ST_HOLD : ST_REPORT;
        ST_REPORT:
          if (TX_REQ && report_idx)
            next_state = ST_HOLD;
        ST_HOLD:
          next_state = ST_HOLD;
        default:
          next_state = ST_IDLE;
      endcase
    end
  end

  // state register and the sleep indication that follows it
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      state     <= ST_IDLE;
      ASLEEP    <= 1'b0;
      wake_prev <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      ASLEEP    <= (next_state == ST_SLEEP);
      wake_prev <= WAKE;
    end
  end

  // ************************************************************
  // configuration byte
  // ************************************************************
  // only the rate field is kept; code 11 falls back to 400k
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      RATE_SELECT <= CFG_RESET[CFG_RATE_MSB:CFG_RATE_LSB];
    else if (state == ST_CFG_WR && rx_take && !BUS_RESET && SLEEP_N)
    begin
      if (RX_BYTE[CFG_RATE_MSB:CFG_RATE_LSB] == RATE_UNUSED)
        RATE_SELECT <= RATE_400K;
      else
        RATE_SELECT <= RX_BYTE[CFG_RATE_MSB:CFG_RATE_LSB];
    end
  end

  // ************************************************************
  // packet fields
  // ************************************************************
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      I2C_ADDR  <= 7'h0;
      I2C_WLEN  <= 8'h0;
      I2C_RLEN  <= 8'h0;
      data_left <= 8'h0;
      rx_crc_lo <= 8'h0;
    end
    else if (rx_take)
    begin
      case (state)
        ST_ADDR:   I2C_ADDR  <= RX_BYTE[7:1];
        ST_WLEN:
        begin
          I2C_WLEN  <= RX_BYTE;
          data_left <= RX_BYTE;
        end
        ST_WDATA:  data_left <= data_left - 8'h01;
        ST_RLEN:   I2C_RLEN  <= RX_BYTE;
        ST_CRC_LO: rx_crc_lo <= RX_BYTE;
        default:   data_left <= data_left;
      endcase
    end
  end

  // one-cycle start pulse, only after a good check
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      I2C_GO <= 1'b0;
    else
      I2C_GO <= (state == ST_CHECK) && pkt_ok && SLEEP_N && !BUS_RESET;
  end

  // ************************************************************
  // error flag
  // ************************************************************
  // zero lengths also flag; a set in the reset cycle is not lost
  assign err_set = SLEEP_N && state != ST_SLEEP
                   && ((state == ST_CHECK && !pkt_ok)
                   || (rx_take && (state == ST_WLEN || state == ST_RLEN)
                       && RX_BYTE == LEN_ZERO));

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      ERR_DETECTED <= 1'b0;
    else if (err_set)
      ERR_DETECTED <= 1'b1;
    else if (BUS_RESET && state != ST_SLEEP)
      ERR_DETECTED <= 1'b0;
  end

  // ************************************************************
  // read answers
  // ************************************************************
  // answer byte is staged at the command so the read can be served at once
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      TX_VALID   <= 1'b0;
      TX_BYTE    <= 8'h0;
      report_idx <= 1'b0;
    end
    else
    begin
      TX_VALID <= 1'b0;
      if (state == ST_CMD && rx_take && RX_BYTE == CMD_READ_CFG)
        TX_BYTE <= {CFG_UPPER, RATE_SELECT};
      else if (state == ST_CMD && rx_take && RX_BYTE == CMD_READ_REV)
        TX_BYTE <= {REV_MAJOR, REV_MINOR};
      else if (state == ST_CHECK)
      begin
        TX_BYTE    <= STAT_CRC_ERR;
        report_idx <= 1'b0;
      end
      else if (state == ST_ANSWER && TX_REQ && next_state == ST_HOLD)
        TX_VALID <= 1'b1;
      else if (state == ST_REPORT && TX_REQ && next_state != ST_SLEEP
               && !BUS_RESET)
      begin
        TX_VALID   <= 1'b1;
        report_idx <= 1'b1;
        if (report_idx)
          TX_BYTE <= WSTAT_NO_I2C;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_rate_reset_ok : assert property (@(posedge CLK_SYS) disable iff (RST)
    RATE_SELECT != RATE_UNUSED)
    else $error("rate select holds the unused code");

  a_cfg_write_store : assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == ST_CFG_WR && rx_take && SLEEP_N && !BUS_RESET
     && RX_BYTE[1:0] != RATE_UNUSED) |=> RATE_SELECT == $past(RX_BYTE[1:0]))
    else $error("configuration write not stored");

  a_cfg_read_back : assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == ST_CMD && rx_take && SLEEP_N && !BUS_RESET && RX_BYTE == CMD_READ_CFG)
    |=> TX_BYTE == {CFG_UPPER, RATE_SELECT})
    else $error("configuration byte not returned");

  a_answer_valid : assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == ST_ANSWER && TX_REQ && SLEEP_N && !BUS_RESET) |=> TX_VALID)
    else $error("answer byte not marked valid");

  a_cmd_after_select : assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == ST_IDLE && !ROM_SELECTED) |=> state != ST_CMD)
    else $error("command accepted without selection");

  a_sleep_cmd : assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == ST_CMD && rx_take && RX_BYTE == CMD_SLEEP && !BUS_RESET)
    |=> ASLEEP && state == ST_SLEEP)
    else $error("sleep command ignored");

  a_sleep_stays : assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == ST_SLEEP && !(WAKE && !wake_prev)) |=> ASLEEP)
    else $error("sleep left without wake edge");

  a_sleep_pin : assert property (@(posedge CLK_SYS) disable iff (RST)
    (!SLEEP_N && state != ST_SLEEP) |=> ASLEEP)
    else $error("sleep pin ignored");

  a_rev_nibbles : assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == ST_CMD && rx_take && SLEEP_N && !BUS_RESET && RX_BYTE == CMD_READ_REV)
    |=> TX_BYTE == {REV_MAJOR, REV_MINOR})
    else $error("revision byte wrong");

  a_crc_go_pulse : assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == ST_CHECK && pkt_ok && SLEEP_N && !BUS_RESET) |=> I2C_GO ##1 !I2C_GO)
    else $error("start pulse wrong after good crc");

  a_crc_bad_flag : assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == ST_CHECK && !pkt_ok && SLEEP_N) |=> ERR_DETECTED && !I2C_GO)
    else $error("crc error not flagged");

  a_err_clear : assert property (@(posedge CLK_SYS) disable iff (RST)
    (BUS_RESET && state != ST_SLEEP && !err_set) |=> !ERR_DETECTED)
    else $error("bus reset did not clear error");

  a_report_bytes : assert property (@(posedge CLK_SYS) disable iff (RST)
    (state == ST_REPORT && TX_REQ && !report_idx && SLEEP_N && !BUS_RESET)
    |=> TX_VALID && TX_BYTE == STAT_CRC_ERR)
    else $error("status byte wrong after crc failure");

endmodule // bcsch_top

// ===== bcsch_host_model.sv
// host-side model of the byte link: bus reset, selection, byte writes and reads
`timescale 1ns/100ps
module bcsch_host_model (
  input  wire logic       clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            bus_reset,
  output logic            rom_selected,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            tx_req
);
  // idle link at time zero
  initial
  begin
    bus_reset    = 1'b0;
    rom_selected = 1'b0;
    rx_valid     = 1'b0;
    rx_byte      = 8'h00;
    tx_req       = 1'b0;
  end

  // every command opens with a bus reset, then a selection unless refused on purpose
  task automatic open_cmd(input logic sel);
    @(posedge clk) bus_reset <= 1'b1;
    @(posedge clk) bus_reset <= 1'b0;
    rom_selected <= sel;
    @(posedge clk) rom_selected <= 1'b0;
  endtask

  // one byte; the released line shows the inverse so a stale byte cannot pass
  task automatic send(input logic [7:0] b);
    @(posedge clk) rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clk) rx_valid <= 1'b0;
    rx_byte <= ~b;
  endtask

  // clocks one read byte and waits a bounded span for the answer
  task automatic read(output logic [7:0] b, output logic got);
    got = 1'b0;
    b   = 8'h00;
    @(posedge clk) tx_req <= 1'b1;
    @(posedge clk) tx_req <= 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      if (tx_valid === 1'b1 && !got)
      begin
        b   = tx_byte;
        got = 1'b1;
      end
    end
  endtask
endmodule // bcsch_host_model

// ===== bcsch_top_tb.sv
// self-checking testbench of the bridge command, sleep and crc handler
`timescale 1ns/100ps
module bcsch_top_tb;
  import bcsch_pkg::*;
  localparam logic [55:0] BODY = 56'h00_0000_0000_5a01; // arbitrary value
  localparam logic [3:0]  MAJ  = 4'h1;
  localparam logic [3:0]  MIN  = 4'h0;

  logic        CLK_SYS = 1'b0;
  logic        RST     = 1'b1;
  logic        SLEEP_N = 1'b1;
  logic        WAKE    = 1'b0;
  logic        BUS_RESET, ROM_SELECTED, RX_VALID, TX_REQ, TX_VALID;
  logic [7:0]  RX_BYTE, TX_BYTE, I2C_WLEN, I2C_RLEN, b;
  logic [1:0]  RATE_SELECT, exp_rate;
  logic        I2C_GO, ERR_DETECTED, ASLEEP, ROM_ID_READY, got;
  logic [6:0]  I2C_ADDR;
  logic [63:0] ROM_ID;
  logic [7:0]  rc;
  int          fail_count = 0;
  int          n_tests    = 0;
  int          go_count   = 0;
  int          g0;

  always #10 CLK_SYS = ~CLK_SYS;

  // counts start pulses so a missing or extra one is seen
  always @(posedge CLK_SYS)
    if (I2C_GO === 1'b1)
      go_count++;

  bcsch_top #(.REV_MAJOR(MAJ), .REV_MINOR(MIN), .ROM_BODY(BODY)) u_dut (
    .CLK_SYS(CLK_SYS), .RST(RST), .BUS_RESET(BUS_RESET), .ROM_SELECTED(ROM_SELECTED),
    .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE), .TX_REQ(TX_REQ), .SLEEP_N(SLEEP_N),
    .WAKE(WAKE), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .RATE_SELECT(RATE_SELECT),
    .I2C_GO(I2C_GO), .I2C_ADDR(I2C_ADDR), .I2C_WLEN(I2C_WLEN), .I2C_RLEN(I2C_RLEN),
    .ERR_DETECTED(ERR_DETECTED), .ASLEEP(ASLEEP), .ROM_ID(ROM_ID),
    .ROM_ID_READY(ROM_ID_READY));

  bcsch_host_model u_host (
    .clk(CLK_SYS), .tx_valid(TX_VALID), .tx_byte(TX_BYTE), .bus_reset(BUS_RESET),
    .rom_selected(ROM_SELECTED), .rx_valid(RX_VALID), .rx_byte(RX_BYTE), .tx_req(TX_REQ));

  // ************************************************************
  // reference crc steps, least significant bit first
  // ************************************************************
  function automatic logic [15:0] crc16(logic [15:0] c, logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC16_POLY_REFL) : (c >> 1);
    return c;
  endfunction

  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC8_POLY_REFL) : (c >> 1);
    return c;
  endfunction

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic rd_cmd(input logic [7:0] cmd, output logic [7:0] v, output logic ok);
    u_host.open_cmd(1'b1);
    u_host.send(cmd);
    u_host.read(v, ok);
  endtask

  // address lsb set on purpose: the crc must still take it as zero
  task automatic packet(input logic [7:0] adr, input logic [15:0] flip);
    logic [7:0]  pk [6];
    logic [15:0] c;
    pk = '{CMD_PACKET, adr, 8'h02, 8'ha5, 8'h3c, 8'h01};
    c  = CRC16_INIT;
    u_host.open_cmd(1'b1);
    for (int i = 0; i < 6; i++)
    begin
      c = crc16(c, (i == 1) ? {pk[i][7:1], 1'b0} : pk[i]);
      u_host.send(pk[i]);
    end
    c = ~c ^ flip;
    u_host.send(c[7:0]);
    u_host.send(c[15:8]);
  endtask

  // hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    #400000;
    fail_count++;
    wrap_up();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (4) @(posedge CLK_SYS);
    RST <= 1'b0;
    check("rate after reset", RATE_SELECT, RATE_400K);
    repeat (10) @(posedge CLK_SYS);
    rc = CRC8_INIT;
    for (int i = 0; i < 7; i++)
      rc = crc8(rc, BODY[8*i +: 8]);
    check("rom id ready", ROM_ID_READY, 1'b1);
    check("rom id", ROM_ID, {rc, BODY});
    rd_cmd(CMD_READ_CFG, b, got);
    check("cfg answered", got, 1'b1);
    check("cfg reset byte", b, CFG_RESET);
    for (int k = 0; k < 4; k++)
    begin
      exp_rate = (k == 3) ? RATE_400K : k[1:0];
      u_host.open_cmd(1'b1);
      u_host.send(CMD_WRITE_CFG);
      u_host.send({6'h3f, k[1:0]}); // upper bits set so a leak shows
      repeat (2) @(posedge CLK_SYS);
      check("rate select", RATE_SELECT, exp_rate);
      rd_cmd(CMD_READ_CFG, b, got);
      check("cfg readback", b, {6'h00, exp_rate});
    end
    u_host.open_cmd(1'b0);
    u_host.send(CMD_READ_REV);
    u_host.read(b, got);
    check("answer without select", got, 1'b0);
    rd_cmd(CMD_READ_REV, b, got);
    check("revision", b, {MAJ, MIN});
    g0 = go_count;
    packet(8'h51, 16'h0000);
    repeat (4) @(posedge CLK_SYS);
    check("start on match", go_count - g0, 1);
    check("i2c address", I2C_ADDR, 7'h28);
    check("write length", I2C_WLEN, 8'h02);
    check("read count", I2C_RLEN, 8'h01);
    check("no error on match", ERR_DETECTED, 1'b0);
    g0 = go_count;
    u_host.open_cmd(1'b1);
    u_host.send(CMD_PACKET);
    u_host.send(8'h51);
    u_host.send(LEN_ZERO);
    repeat (2) @(posedge CLK_SYS);
    check("no start on zero length", go_count - g0, 0);
    check("error on zero length", ERR_DETECTED, 1'b1);
    g0 = go_count;
    packet(8'h51, 16'h0100);
    repeat (4) @(posedge CLK_SYS);
    check("no start on mismatch", go_count - g0, 0);
    check("error on mismatch", ERR_DETECTED, 1'b1);
    u_host.read(b, got);
    check("status byte", b, STAT_CRC_ERR);
    u_host.read(b, got);
    check("write status", b, WSTAT_NO_I2C);
    u_host.open_cmd(1'b1);
    @(posedge CLK_SYS);
    check("error cleared", ERR_DETECTED, 1'b0);
    u_host.send(CMD_SLEEP);
    @(posedge CLK_SYS);
    check("asleep by command", ASLEEP, 1'b1);
    rd_cmd(CMD_READ_CFG, b, got);
    check("traffic ignored", got, 1'b0);
    check("bus cannot wake", ASLEEP, 1'b1);
    @(posedge CLK_SYS) WAKE <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    check("woken by edge", ASLEEP, 1'b0);
    WAKE <= 1'b0;
    @(posedge CLK_SYS) SLEEP_N <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    check("asleep by pin", ASLEEP, 1'b1);
    SLEEP_N <= 1'b1;
    @(posedge CLK_SYS) WAKE <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    check("woken after pin", ASLEEP, 1'b0);
    WAKE <= 1'b0;
    rd_cmd(CMD_READ_CFG, b, got);
    check("answers when awake", got, 1'b1);
    wrap_up();
  end
endmodule // bcsch_top_tb
